// ===== hdl/tw_timer2.sv
// timer/counter control slice with its ahb-lite register slave
`include "tw_timer_regs.svh"
module tw_timer2 (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic chanBMatchAck,
	output logic chanBMatchFlag,
	output logic chanAWavePin,
	output logic chanAOverride,
	output logic chanBWavePin,
	output logic chanBOverride
);
	tw_pkg::tw_bus_e busState_q;
	tw_pkg::tw_bus_e busState_d;
	logic [7:0] addrIdx_q;
	logic addrOk_q;
	logic [31:0] hrdata_q;
	logic [7:0] ctrlA_q;
	logic [7:0] ctrlB_q;
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic dirUp_q;
	logic dirUp_d;
	logic blockMatch_q;
	logic [7:0] cmpBufA_q;
	logic [7:0] cmpBufB_q;
	logic [7:0] cmpActA_q;
	logic [7:0] cmpActB_q;
	logic [2:0] flags_q;
	logic [2:0] flags_d;

	// bus decode
	logic takeReq;
	logic wrEn;
	logic [7:0] wrData;
	logic [7:0] rdData;
	logic wrCtrlA;
	logic wrCtrlB;
	logic wrCount;
	logic wrCmpA;
	logic wrCmpB;
	logic wrFlags;

	function automatic logic regHit(input logic [7:0] idx, input logic ok, input logic [7:0] want);
		return ok && (idx == want);
	endfunction

	assign takeReq = hsel & htrans[1] & hready;
	assign wrEn = (busState_q == tw_pkg::busWrite);
	assign wrData = hwdata[7:0];
	assign wrCtrlA = wrEn & regHit(addrIdx_q, addrOk_q, `TW_IDX_CTRL_A);
	assign wrCtrlB = wrEn & regHit(addrIdx_q, addrOk_q, `TW_IDX_CTRL_B);
	assign wrCount = wrEn & regHit(addrIdx_q, addrOk_q, `TW_IDX_COUNT);
	assign wrCmpA = wrEn & regHit(addrIdx_q, addrOk_q, `TW_IDX_CMP_A);
	assign wrCmpB = wrEn & regHit(addrIdx_q, addrOk_q, `TW_IDX_CMP_B);
	assign wrFlags = wrEn & regHit(addrIdx_q, addrOk_q, `TW_IDX_FLAGS);

	// one wait state on reads so a read right after a write sees it
	assign hreadyout = (busState_q != tw_pkg::busRdWait);
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_comb begin
		busState_d = busState_q;
		case (busState_q)
			tw_pkg::busRdWait: busState_d = tw_pkg::busRdDone;
			tw_pkg::busIdle, tw_pkg::busWrite, tw_pkg::busRdDone: begin
				if (takeReq) begin
					busState_d = hwrite ? tw_pkg::busWrite : tw_pkg::busRdWait;
				end else begin
					busState_d = tw_pkg::busIdle;
				end
			end
			default: busState_d = tw_pkg::busIdle;
		endcase
	end

	// mode decode
	logic [2:0] wgm;
	tw_pkg::tw_kind_e modeKind;
	logic isPwm;
	logic topIsCmpA;
	logic [7:0] topVal;
	logic atTop;
	logic atMax;
	logic atBottom;
	logic tick;

	assign wgm = {ctrlB_q[`TW_CB_WGM_BIT], ctrlA_q[`TW_CA_WGM_HI:`TW_CA_WGM_LO]};
	always_comb begin
		case (wgm)
			3'h0: modeKind = tw_pkg::kindNormal;
			3'h1, 3'h5: modeKind = tw_pkg::kindPhase;
			3'h2: modeKind = tw_pkg::kindClear;
			3'h3, 3'h7: modeKind = tw_pkg::kindFast;
			default: modeKind = tw_pkg::kindReserved;
		endcase
	end
	assign isPwm = (modeKind == tw_pkg::kindPhase) || (modeKind == tw_pkg::kindFast);
	assign topIsCmpA = (wgm == 3'h2) || (wgm == 3'h5) || (wgm == 3'h7);
	assign topVal = topIsCmpA ? cmpActA_q : `TW_MAX;
	assign atTop = (count_q == topVal);
	assign atMax = (count_q == `TW_MAX);
	assign atBottom = (count_q == `TW_BOTTOM);

	tw_prescaler uPre (
		.clk(clk),
		.resetn(resetn),
		.clockSelect(ctrlB_q[`TW_CB_CS_HI:`TW_CB_CS_LO]),
		.tick(tick)
	);

	// counter sequencing
	logic ovfEvt;
	always_comb begin
		count_d = count_q;
		dirUp_d = dirUp_q;
		ovfEvt = 1'b0;
		if (tick) begin
			case (modeKind)
				tw_pkg::kindPhase: begin
					if (dirUp_q) begin
						if (atTop) begin
							dirUp_d = 1'b0;
							count_d = count_q - 8'h01;
						end else begin
							count_d = count_q + 8'h01;
						end
					end else if (atBottom) begin
						dirUp_d = 1'b1;
						count_d = count_q + 8'h01;
						ovfEvt = 1'b1;
					end else begin
						count_d = count_q - 8'h01;
					end
				end
				tw_pkg::kindClear, tw_pkg::kindFast: begin
					count_d = atTop ? `TW_BOTTOM : count_q + 8'h01;
					ovfEvt = (wgm == 3'h7) ? atTop : atMax;
				end
				default: begin
					count_d = count_q + 8'h01;
					ovfEvt = atMax;
				end
			endcase
		end
		if (wrCount) begin
			count_d = wrData;
		end
	end

	// compare units; a blocked tick drops matches on both channels
	logic matchA;
	logic matchB;
	logic loadBuf;
	logic forceA;
	logic forceB;
	assign matchA = tick & ~blockMatch_q & (count_q == cmpActA_q);
	assign matchB = tick & ~blockMatch_q & (count_q == cmpActB_q);
	assign loadBuf = (modeKind == tw_pkg::kindPhase) ? (tick & atTop & dirUp_q) : (tick & atTop);
	assign forceA = wrCtrlB & wrData[`TW_CB_FORCE_A] & ~isPwm;
	assign forceB = wrCtrlB & wrData[`TW_CB_FORCE_B] & ~isPwm;

	// hardware set wins over software or ack clear; forces never set flags
	always_comb begin
		flags_d = flags_q;
		if (wrFlags) begin
			flags_d = flags_q & ~wrData[2:0];
		end
		if (chanBMatchAck) begin
			flags_d[`TW_FL_MATCH_B] = 1'b0;
		end
		flags_d[`TW_FL_OVF] = flags_d[`TW_FL_OVF] | ovfEvt;
		flags_d[`TW_FL_MATCH_A] = flags_d[`TW_FL_MATCH_A] | matchA;
		flags_d[`TW_FL_MATCH_B] = flags_d[`TW_FL_MATCH_B] | matchB;
	end
	assign chanBMatchFlag = flags_q[`TW_FL_MATCH_B];

	tw_wave_unit uWaveA (
		.clk(clk),
		.resetn(resetn),
		.modeKind(modeKind),
		.outMode(ctrlA_q[`TW_CA_COMA_HI:`TW_CA_COMA_LO]),
		.tick(tick),
		.matchHit(matchA),
		.atTop(atTop),
		.countUp(dirUp_q),
		.cmpEqTop(cmpActA_q == topVal),
		.forceHit(forceA),
		.wave(chanAWavePin)
	);

	tw_wave_unit uWaveB (
		.clk(clk),
		.resetn(resetn),
		.modeKind(modeKind),
		.outMode(ctrlA_q[`TW_CA_COMB_HI:`TW_CA_COMB_LO]),
		.tick(tick),
		.matchHit(matchB),
		.atTop(atTop),
		.countUp(dirUp_q),
		.cmpEqTop(cmpActB_q == topVal),
		.forceHit(forceB),
		.wave(chanBWavePin)
	);

	// port logic still needs its direction bit set to drive the pin
	assign chanAOverride = |ctrlA_q[`TW_CA_COMA_HI:`TW_CA_COMA_LO];
	assign chanBOverride = |ctrlA_q[`TW_CA_COMB_HI:`TW_CA_COMB_LO];

	// read mux; force bits and reserved bits read as zero
	always_comb begin
		rdData = 8'h00;
		if (addrOk_q) begin
			case (addrIdx_q)
				`TW_IDX_CTRL_A: rdData = ctrlA_q;
				`TW_IDX_CTRL_B: rdData = ctrlB_q & `TW_CB_MASK;
				`TW_IDX_COUNT: rdData = count_q;
				`TW_IDX_CMP_A: rdData = cmpBufA_q;
				`TW_IDX_CMP_B: rdData = cmpBufB_q;
				`TW_IDX_FLAGS: rdData = {5'h00, flags_q};
				default: rdData = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			busState_q <= tw_pkg::busIdle;
			addrIdx_q <= 8'h00;
			addrOk_q <= 1'b0;
			hrdata_q <= 32'h0000_0000;
		end else begin
			busState_q <= busState_d;
			if (takeReq) begin
				addrIdx_q <= haddr[9:2];
				addrOk_q <= (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
			end
			if (busState_q == tw_pkg::busRdWait) begin
				hrdata_q <= {24'h00_0000, rdData};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrlA_q <= `TW_RST_CTRL_A;
			ctrlB_q <= `TW_RST_CTRL_B;
		end else begin
			if (wrCtrlA) begin
				ctrlA_q <= wrData & `TW_CA_MASK;
			end
			if (wrCtrlB) begin
				ctrlB_q <= wrData & `TW_CB_MASK;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			count_q <= `TW_RST_COUNT;
			dirUp_q <= 1'b1;
			blockMatch_q <= 1'b0;
			flags_q <= 3'h0;
		end else begin
			count_q <= count_d;
			dirUp_q <= dirUp_d;
			blockMatch_q <= wrCount | (blockMatch_q & ~tick);
			flags_q <= flags_d;
		end
	end

	// compare buffers: direct in non-pwm, else copied at the update point
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cmpBufA_q <= `TW_RST_CMP;
			cmpBufB_q <= `TW_RST_CMP;
			cmpActA_q <= `TW_RST_CMP;
			cmpActB_q <= `TW_RST_CMP;
		end else begin
			if (wrCmpA) begin
				cmpBufA_q <= wrData;
			end
			if (wrCmpB) begin
				cmpBufB_q <= wrData;
			end
			if (!isPwm) begin
				cmpActA_q <= wrCmpA ? wrData : cmpBufA_q;
				cmpActB_q <= wrCmpB ? wrData : cmpBufB_q;
			end else if (loadBuf) begin
				cmpActA_q <= cmpBufA_q;
				cmpActB_q <= cmpBufB_q;
			end
		end
	end
endmodule

// ===== hdl/tw_timer_regs.svh
// register indices, field positions, reset values and counts of the timer slice
`ifndef TW_TIMER_REGS_SVH
`define TW_TIMER_REGS_SVH

// register indices; byte address is four times the index
`define TW_IDX_CTRL_A 8'hb0
`define TW_IDX_CTRL_B 8'hb1
`define TW_IDX_COUNT 8'hb2
`define TW_IDX_CMP_A 8'hb3
`define TW_IDX_CMP_B 8'hb4
`define TW_IDX_FLAGS 8'hb5

// control a fields
`define TW_CA_COMA_HI 7
`define TW_CA_COMA_LO 6
`define TW_CA_COMB_HI 5
`define TW_CA_COMB_LO 4
`define TW_CA_WGM_HI 1
`define TW_CA_WGM_LO 0
`define TW_CA_MASK 8'hf3

// control b fields
`define TW_CB_FORCE_A 7
`define TW_CB_FORCE_B 6
`define TW_CB_WGM_BIT 3
`define TW_CB_CS_HI 2
`define TW_CB_CS_LO 0
`define TW_CB_MASK 8'h0f

// flag fields
`define TW_FL_OVF 0
`define TW_FL_MATCH_A 1
`define TW_FL_MATCH_B 2

// reset values
`define TW_RST_CTRL_A 8'h00
`define TW_RST_CTRL_B 8'h00
`define TW_RST_COUNT 8'h00
`define TW_RST_CMP 8'h00

// counter limits
`define TW_MAX 8'hff
`define TW_BOTTOM 8'h00

// prescaler divider exponents: 8, 32, 64, 128, 256, 1024
`define TW_PRE_BITS 10
`define TW_LOG_DIV8 3
`define TW_LOG_DIV32 5
`define TW_LOG_DIV64 6
`define TW_LOG_DIV128 7
`define TW_LOG_DIV256 8
`define TW_LOG_DIV1024 10

`endif

// ===== hdl/tw_pkg.sv
// types shared by the timer slice
package tw_pkg;
	typedef enum logic [2:0] {
		kindNormal,
		kindPhase,
		kindClear,
		kindFast,
		kindReserved
	} tw_kind_e;

	typedef enum logic [1:0] {
		busIdle,
		busWrite,
		busRdWait,
		busRdDone
	} tw_bus_e;
endpackage

// ===== hdl/tw_prescaler.sv
// clock select decoder and free running prescaler
`include "tw_timer_regs.svh"
module tw_prescaler (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [2:0] clockSelect,
	output logic tick
);
	logic [`TW_PRE_BITS-1:0] preCount_q;
	logic [`TW_PRE_BITS-1:0] preCount_d;

	function automatic logic lowOnes(input logic [`TW_PRE_BITS-1:0] v, input int n);
		logic r;
		r = 1'b1;
		for (int i = 0; i < `TW_PRE_BITS; i++) begin
			if (i < n && !v[i]) begin
				r = 1'b0;
			end
		end
		return r;
	endfunction

	assign preCount_d = preCount_q + `TW_PRE_BITS'(1);

	// one shared divider; each tap ticks once per wrap of its low bits
	always_comb begin
		case (clockSelect)
			3'h0: tick = 1'b0;
			3'h1: tick = 1'b1;
			3'h2: tick = lowOnes(preCount_q, `TW_LOG_DIV8);
			3'h3: tick = lowOnes(preCount_q, `TW_LOG_DIV32);
			3'h4: tick = lowOnes(preCount_q, `TW_LOG_DIV64);
			3'h5: tick = lowOnes(preCount_q, `TW_LOG_DIV128);
			3'h6: tick = lowOnes(preCount_q, `TW_LOG_DIV256);
			default: tick = lowOnes(preCount_q, `TW_LOG_DIV1024);
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			preCount_q <= '0;
		end else begin
			preCount_q <= preCount_d;
		end
	end
endmodule

// ===== hdl/tw_wave_unit.sv
// waveform generator for one compare channel
module tw_wave_unit (
	input wire logic clk,
	input wire logic resetn,
	input tw_pkg::tw_kind_e modeKind,
	input wire logic [1:0] outMode,
	input wire logic tick,
	input wire logic matchHit,
	input wire logic atTop,
	input wire logic countUp,
	input wire logic cmpEqTop,
	input wire logic forceHit,
	output logic wave
);
	logic wave_q;
	logic wave_d;
	logic setAct;
	logic clrAct;
	logic tglAct;
	logic special;

	assign special = cmpEqTop & outMode[1];

	always_comb begin
		setAct = 1'b0;
		clrAct = 1'b0;
		tglAct = 1'b0;
		case (modeKind)
			tw_pkg::kindNormal, tw_pkg::kindClear: begin
				// forced match uses the mode bits of this very cycle
				if (matchHit || forceHit) begin
					tglAct = (outMode == 2'h1);
					clrAct = (outMode == 2'h2);
					setAct = (outMode == 2'h3);
				end
			end
			tw_pkg::kindFast: begin
				if (matchHit && !special) begin
					clrAct = (outMode == 2'h2);
					setAct = (outMode == 2'h3);
				end
				// wrap to bottom happens on the top tick
				if (tick && atTop) begin
					setAct = (outMode == 2'h2);
					clrAct = (outMode == 2'h3);
				end
			end
			tw_pkg::kindPhase: begin
				if (matchHit && !special) begin
					clrAct = countUp ? (outMode == 2'h2) : (outMode == 2'h3);
					setAct = countUp ? (outMode == 2'h3) : (outMode == 2'h2);
				end
				if (special && tick && atTop) begin
					setAct = (outMode == 2'h2);
					clrAct = (outMode == 2'h3);
				end
			end
			default: begin
			end
		endcase
	end

	assign wave_d = tglAct ? ~wave_q : (setAct ? 1'b1 : (clrAct ? 1'b0 : wave_q));
	assign wave = wave_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			wave_q <= 1'b0;
		end else begin
			wave_q <= wave_d;
		end
	end
endmodule

// ===== sim/tw_timer2_assertions.sv
// port-level assertions for the timer slice
module tw_timer2_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic chanBMatchAck,
	input wire logic chanBMatchFlag,
	input wire logic chanAOverride,
	input wire logic chanBOverride
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	wire rdGo = hsel && htrans[1] && hready && !hwrite;
	wire wrGo = hsel && htrans[1] && hready && hwrite;
	logic wrData_q;
	// control registers only change at the edge closing a write data phase
	always_ff @(posedge clk) wrData_q <= resetn && wrGo;
	sequence oneWait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_wait: assert property (rdGo |=> oneWait)
		else $error("read wait state wrong");
	a_write_nowait: assert property (wrGo |=> hreadyout)
		else $error("write stalled");
	a_wait_cause: assert property (!hreadyout |-> $past(rdGo))
		else $error("wait without read");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_rdata_upper: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_override_a: assert property ($changed(chanAOverride) |-> $past(wrData_q))
		else $error("override a moved without write");
	a_override_b: assert property ($changed(chanBOverride) |-> $past(wrData_q))
		else $error("override b moved without write");
	a_flag_clear: assert property ($fell(chanBMatchFlag) |-> $past(chanBMatchAck) || $past(wrData_q))
		else $error("match b flag fell without cause");
endmodule
bind tw_timer2 tw_timer2_checker ck (.clk(clk), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chanBMatchAck(chanBMatchAck),
	.chanBMatchFlag(chanBMatchFlag), .chanAOverride(chanAOverride), .chanBOverride(chanBOverride));

// ===== sim/tw_port_model.sv
// port logic sharing the channel b pin
module tw_port_model (
	input wire logic override,
	input wire logic wave,
	input wire logic dirOut,
	input wire logic portOut,
	output logic pinLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// released pad floats up through its pull-up
	assign pinLevel = !dirOut ? 1'b1 : (override ? wave : portOut);
endmodule

// ===== sim/timer2_waveform_control_test.sv
// self-checking bench for the timer slice
`include "tw_timer_regs.svh"
module timer2_waveform_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, hsel, hwrite, chanBMatchAck, dirOut, portOut, hreadyout, hresp;
	logic chanBMatchFlag, chanAWavePin, chanAOverride, chanBWavePin, chanBOverride, pinLevel;
	logic [31:0] haddr, hwdata, hrdata, seed;
	logic [1:0] htrans;
	int fails, check_count;
	int divTab[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	tw_timer2 dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .chanBMatchAck(chanBMatchAck), .chanBMatchFlag(chanBMatchFlag),
		.chanAWavePin(chanAWavePin), .chanAOverride(chanAOverride), .chanBWavePin(chanBWavePin),
		.chanBOverride(chanBOverride));
	tw_port_model port (.override(chanBOverride), .wave(chanBWavePin), .dirOut(dirOut), .portOut(portOut),
		.pinLevel(pinLevel));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// compare a is held at 0x3f while the pwm modes run
	function automatic int topOf(input int mode);
		return (mode > 4) ? 63 : 255;
	endfunction
	function automatic int period(input int mode);
		return (mode % 4 == 3) ? topOf(mode) + 1 : 2 * topOf(mode);
	endfunction
	task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// hready is looked at just before the edge that samples it
	task automatic waitRdy(output logic [31:0] d);
		logic ok;
		ok = 1'b0;
		while (!ok) begin
			@(negedge clk);
			ok = hreadyout === 1'b1;
			d = hrdata;
			@(posedge clk);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'b00};
		waitRdy(d);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, wd};
		waitRdy(d);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] d;
		bus(1'b1, idx, wd, d);
	endtask
	task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] d;
		bus(1'b0, idx, 8'h00, d);
		chk(exp, d, what);
	endtask
	task automatic highs(input int n, output int hi);
		hi = 0;
		repeat (n) begin
			@(negedge clk);
			if (chanBWavePin === 1'b1) hi++;
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		$display("[ERR] run expected done seen hang");
		test_done();
	end
	initial begin
		logic [7:0] v;
		static logic [1:0] codes[5] = '{3, 2, 1, 1, 0};
		logic expW;
		logic [31:0] d;
		int hi, sum, t, p;
		static int modes[4] = '{3, 7, 1, 5};
		seed = 32'd89;
		{resetn, hsel, hwrite, chanBMatchAck, dirOut, portOut, expW} = '0;
		haddr = '0;
		hwdata = '0;
		htrans = '0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		rdChk(`TW_IDX_CTRL_A, 0, "ctrl a");
		rdChk(`TW_IDX_CTRL_B, 0, "ctrl b");
		rdChk(`TW_IDX_COUNT, 0, "count");
		rdChk(8'h10, 0, "unmapped");
		$display("reset test done");
		foreach (codes[i]) begin
			v = 8'(xs());
			dirOut <= v[0];
			portOut <= v[1];
			wr(`TW_IDX_CTRL_A, {codes[i], codes[i], 4'h0});
			wr(`TW_IDX_CTRL_B, 8'hc0);
			@(negedge clk);
			expW = codes[i] == 1 ? !expW : codes[i] == 3 ? 1'b1 : codes[i] == 2 ? 1'b0 : expW;
			chk(codes[i] != 0, chanBOverride, "override b");
			chk(codes[i] != 0, chanAOverride, "override a");
			chk(!dirOut ? 1'b1 : codes[i] != 0 ? expW : portOut, pinLevel, "pin");
			if (codes[i] != 0) chk({expW, expW}, {chanAWavePin, chanBWavePin}, "waves");
		end
		rdChk(`TW_IDX_CTRL_B, 0, "force read");
		rdChk(`TW_IDX_FLAGS, 0, "force flags");
		v = 8'(xs());
		wr(`TW_IDX_CTRL_A, 8'h22);
		wr(`TW_IDX_COUNT, v);
		wr(`TW_IDX_CTRL_B, 8'h40);
		rdChk(`TW_IDX_COUNT, v, "force count");
		wr(`TW_IDX_CTRL_A, 8'h33);
		wr(`TW_IDX_CTRL_B, 8'h40);
		@(negedge clk);
		chk(0, chanBWavePin, "pwm force");
		wr(`TW_IDX_CTRL_A, 8'h00);
		v = 8'(xs());
		wr(`TW_IDX_CTRL_B, v & 8'hf7);
		rdChk(`TW_IDX_CTRL_B, v & 8'h07, "ctrl b mask");
		$display("force test done");
		for (int cs = 1; cs < 8; cs++) begin
			wr(`TW_IDX_CTRL_B, 8'h00);
			wr(`TW_IDX_COUNT, 8'h00);
			wr(`TW_IDX_CTRL_B, 8'(cs));
			repeat (4 * divTab[cs]) @(posedge clk);
			bus(1'b0, `TW_IDX_COUNT, 8'h00, d);
			t = (4 * divTab[cs] + 2) / divTab[cs];
			chk(1, d + 1 >= t && d <= t + 1, "count rate");
		end
		wr(`TW_IDX_CTRL_B, 8'h00);
		wr(`TW_IDX_CMP_B, 8'h40);
		wr(`TW_IDX_FLAGS, 8'h07);
		wr(`TW_IDX_CTRL_B, 8'h01);
		wr(`TW_IDX_COUNT, 8'h40);
		bus(1'b0, `TW_IDX_FLAGS, 8'h00, d);
		chk(0, d[2], "masked match");
		// one below compare: blocked tick passes, match lands before the read capture
		wr(`TW_IDX_COUNT, 8'h3f);
		bus(1'b0, `TW_IDX_FLAGS, 8'h00, d);
		chk(1, d[2] & chanBMatchFlag, "match flag");
		@(posedge clk);
		chanBMatchAck <= 1'b1;
		@(posedge clk);
		chanBMatchAck <= 1'b0;
		@(negedge clk);
		chk(0, chanBMatchFlag, "ack clear");
		wr(`TW_IDX_COUNT, 8'h3e);
		repeat (8) @(posedge clk);
		wr(`TW_IDX_FLAGS, 8'h04);
		rdChk(`TW_IDX_FLAGS, 0, "one clear");
		$display("match test done");
		wr(`TW_IDX_CMP_A, 8'h3f);
		wr(`TW_IDX_CMP_B, 8'(xs() % 63));
		wr(`TW_IDX_CTRL_A, 8'h12);
		repeat (300) @(posedge clk);
		highs(128, hi);
		chk(64, hi, "ctc toggle");
		foreach (modes[m]) begin
			t = topOf(modes[m]);
			p = period(modes[m]);
			v = 8'(1 + xs() % (t - 1));
			for (int k = 0; k < 2; k++) begin
				sum = 0;
				wr(`TW_IDX_CMP_B, k ? 8'(t) : v);
				for (int c = 2; c < 4; c++) begin
					wr(`TW_IDX_CTRL_A, 8'(c * 16 + modes[m] % 4));
					wr(`TW_IDX_CTRL_B, 8'(modes[m] / 4 * 8 + 1));
					repeat (2 * p + 256) @(posedge clk);
					highs(p, hi);
					sum += hi;
					if (k) chk(c == 2 ? p : 0, hi, "top duty");
				end
				chk(p, sum, "duty sum");
			end
		end
		$display("waveform test done");
		test_done();
	end
endmodule
